// [include/sbpa_params.svh]
// What this block does
// - Drive socket B address latch strobe when an access to socket B region starts.
// - Attribute line 1 shows user or supervisor state for core transfers.
// - Attribute line 2 tells instruction from data for core transfers.
// - Attribute line 0 high for communications processor, low for CPU.
// - Attribute line 3 shows reservation for core transfers, on data and fetch alike.
// - Attribute lines driven only for own transactions, released for external masters.
// - Sense socket B input pins; report level and latch level changes.
// - Sample 16-bit width input for socket B I/O region transactions.
// - Instruction watchpoint outputs 0-2 report instruction watchpoint hits.
// - Load/store watchpoint outputs 0-1 report data watchpoint hits.
// - Two queue-flush outputs encode instructions flushed from instruction queue.
// - Two history-flush outputs encode instructions flushed from history buffer.
// - Program trace output asserted while an instruction fetch takes place.
// - Output port lines 0-1 follow socket A control register, reset low.
// - Output port lines 2-3 follow socket B control register.
// - Sample two clock straps at power-on reset release for clock mode.
// - Special transfer start at external transfer start, or internal in show-cycle.
// - Debug serial output data shifted out on shared data-out pin.
`ifndef SBPA_PARAMS_SVH
`define SBPA_PARAMS_SVH

// Register addresses (word index)
`define SBPA_ADDR_PIN_STATE   4'h0
`define SBPA_ADDR_PIN_CHANGE  4'h1
`define SBPA_ADDR_GCTRL_A     4'h2
`define SBPA_ADDR_GCTRL_B     4'h3
`define SBPA_ADDR_PIN_SEL     4'h4
`define SBPA_ADDR_STRAPS      4'h5
// Field positions
`define SBPA_GCTRL_OP_LSB     0
`define SBPA_STRAP_VALID_BIT  2
// Reset values
`define SBPA_GCTRL_RST        2'h0
`define SBPA_PIN_SEL_RST      8'h00
// Pin function codes
`define SBPA_FN_DEBUG         2'h1
`define SBPA_FN_ALT           2'h2

`endif

// [include/sbpa_pkg.sv]
package sbpa_pkg;

  typedef enum logic [1:0]
  {
    SBPA_INIT_CPU = 2'b00,
    SBPA_INIT_CPM = 2'b01,
    SBPA_INIT_EXT = 2'b10
  } sbpa_init_t;

  // Bus transaction started by an internal or external master
  typedef struct packed
  {
    logic       start;
    sbpa_init_t initiator;
    logic       supervisor;
    logic       instr;
    logic       reserve;
    logic       socket_b;
    logic       io_region;
    logic       internal;
  } sbpa_xact_t;

  // Core trace and watchpoint events
  typedef struct packed
  {
    logic [2:0] instr_watch;
    logic [1:0] data_watch;
    logic [1:0] queue_flush;
    logic [1:0] history_flush;
    logic       fetch;
  } sbpa_trace_t;

  typedef enum logic [1:0]
  {
    SBPA_ST_IDLE = 2'b00,
    SBPA_ST_SHIFT = 2'b01
  } sbpa_dbg_state_t;

endpackage : sbpa_pkg

// [rtl/sbpa_pins.sv]
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "sbpa_params.svh"

module sbpa_pins
  import sbpa_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        power_on_reset_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Core side
  input  wire sbpa_xact_t  xact,
  input  wire logic        show_cycle,
  input  wire sbpa_trace_t trace,
  input  wire logic        dbg_tx_load,
  input  wire logic [7:0]  dbg_tx_data,
  output logic      [7:0]  dbg_rx_data,
  output logic             dbg_rx_valid,
  output logic             io_width16_reg,
  output logic      [1:0]  clock_mode,
  // Pin J1
  input  wire logic        pin_j1_i,
  output logic             pin_j1_o,
  output logic             pin_j1_oe,
  // Pins H2, J3
  input  wire logic [1:0]  pin_h2j3_i,
  output logic      [1:0]  pin_h2j3_o,
  output logic      [1:0]  pin_h2j3_oe,
  // Pins J2, G1, G2, J4, K3, H1
  input  wire logic [5:0]  pin_misc_i,
  output logic      [5:0]  pin_misc_o,
  output logic      [5:0]  pin_misc_oe,
  // Output port pins L4, L2 and L1, M4
  output logic      [1:0]  socket_output_port_a,
  input  wire logic [1:0]  pin_l1m4_i,
  output logic      [1:0]  pin_l1m4_o,
  output logic      [1:0]  pin_l1m4_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [10:0] pin_meta_reg;
  logic [10:0] pin_sync_reg;
  wire  [10:0] pin_raw = {pin_l1m4_i, pin_misc_i, pin_h2j3_i, pin_j1_i};
  logic       por_meta_reg;
  logic       por_sync_reg;
  logic       por_prev_reg;

  always_ff @(posedge sys_clk)
  begin
    pin_meta_reg <= pin_raw;
    pin_sync_reg <= pin_meta_reg;
    por_meta_reg <= power_on_reset_n;
    por_sync_reg <= por_meta_reg;
    por_prev_reg <= por_sync_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] pin_change_reg;
  logic [7:0] pin_sel_reg;
  logic [1:0] gctrl_a_reg;
  logic [1:0] gctrl_b_reg;
  logic [2:0] strap_reg;
  logic [7:0] sense_prev_reg;

  // Pin function select: 0 sense (strobe on J1, output port on L1/M4), 1 debug, 2 alternate
  wire [1:0] fn_j1   = pin_sel_reg[1:0];
  wire [1:0] fn_trc  = pin_sel_reg[3:2];
  wire [1:0] fn_k3h1 = pin_sel_reg[5:4];
  wire [1:0] fn_l1m4 = pin_sel_reg[7:6];

  // Socket B input port bits, sensed only when the pin is in sense mode
  wire sense_j1  = (fn_j1 == 2'h0);
  wire sense_trc = (fn_trc == 2'h0);
  wire sense_k3h = (fn_k3h1 == 2'h0);
  wire [7:0] sense_en = {sense_k3h, sense_k3h, {4{sense_trc}},
                         {2{sense_trc}}};
  // Bit 0-1 from H2/J3, 2 from J2, 3-5 from G1/G2/J4, 6-7 from K3/H1
  wire [7:0] socket_b_sense_in = {pin_sync_reg[8:7], pin_sync_reg[6:4],
                                  pin_sync_reg[3], pin_sync_reg[2:1]};
  wire [7:0] sense_live = socket_b_sense_in & sense_en;
  wire [7:0] sense_edge = (sense_live ^ sense_prev_reg) & sense_en;

  wire wr_change = reg_wr && (reg_addr == `SBPA_ADDR_PIN_CHANGE);
  wire wr_a      = reg_wr && (reg_addr == `SBPA_ADDR_GCTRL_A);
  wire wr_b      = reg_wr && (reg_addr == `SBPA_ADDR_GCTRL_B);
  wire wr_sel    = reg_wr && (reg_addr == `SBPA_ADDR_PIN_SEL);

  // Write one to clear; a change in the same cycle wins
  wire [7:0] pin_change_next = (pin_change_reg & ~({8{wr_change}} &
                               reg_wdata[7:0])) | sense_edge;

  // Straps caught on power-on reset release, with straps as inputs
  wire por_release = por_sync_reg && !por_prev_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_change_reg <= 8'h00;
      pin_sel_reg    <= `SBPA_PIN_SEL_RST;
      gctrl_a_reg    <= `SBPA_GCTRL_RST;
      gctrl_b_reg    <= `SBPA_GCTRL_RST;
      sense_prev_reg <= 8'h00;
    end
    else
    begin
      pin_change_reg <= pin_change_next;
      sense_prev_reg <= sense_live;
      if (wr_a)
        gctrl_a_reg <= reg_wdata[1:0];
      if (wr_b)
        gctrl_b_reg <= reg_wdata[1:0];
      if (wr_sel)
        pin_sel_reg <= reg_wdata[7:0];
    end
  end

  // Straps survive soft reset; only power-on release reloads them
  always_ff @(posedge sys_clk)
  begin
    if (por_release)
      strap_reg <= {1'b1, pin_sync_reg[10], pin_sync_reg[9]};
  end

  wire [31:0] rd_mux =
    (reg_addr == `SBPA_ADDR_PIN_STATE)  ? {24'h0, sense_live} :
    (reg_addr == `SBPA_ADDR_PIN_CHANGE) ? {24'h0, pin_change_reg} :
    (reg_addr == `SBPA_ADDR_GCTRL_A)    ? {30'h0, gctrl_a_reg} :
    (reg_addr == `SBPA_ADDR_GCTRL_B)    ? {30'h0, gctrl_b_reg} :
    (reg_addr == `SBPA_ADDR_PIN_SEL)    ? {24'h0, pin_sel_reg} :
    (reg_addr == `SBPA_ADDR_STRAPS)     ? {29'h0, strap_reg} : 32'h0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transaction attributes

  wire own_xact  = xact.start && (xact.initiator != SBPA_INIT_EXT);
  wire core_xact = xact.start && (xact.initiator == SBPA_INIT_CPU);
  wire ale_b     = xact.start && xact.socket_b;
  wire at0       = (xact.initiator == SBPA_INIT_CPM);
  wire at1       = core_xact && xact.supervisor;
  wire at2       = core_xact && xact.instr;
  wire at3       = core_xact && xact.reserve;
  wire sts       = xact.start && (!xact.internal || show_cycle);
  wire io16_samp = xact.start && xact.socket_b && xact.io_region;

  ////////////////////////////////////////////////////////////////////////
  // Debug serial port on J1 clock, K3 data in, M4 data out

  logic [7:0] dbg_sh_reg;
  logic [7:0] dbg_rx_reg;
  logic [2:0] dbg_cnt_reg;
  logic       dclk_prev_reg;
  logic       dbg_out_reg;
  sbpa_dbg_state_t dbg_state_reg;

  wire dbg_on   = (fn_j1 == `SBPA_FN_DEBUG);
  wire dclk     = pin_sync_reg[0] && dbg_on;
  wire dclk_up  = dclk && !dclk_prev_reg;
  wire dclk_dn  = !dclk && dclk_prev_reg;
  wire debug_serial_in     = pin_sync_reg[7] && (fn_k3h1 == `SBPA_FN_DEBUG);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dbg_state_reg <= SBPA_ST_IDLE;
      dbg_sh_reg    <= 8'h00;
      dbg_rx_reg    <= 8'h00;
      dbg_cnt_reg   <= 3'h0;
      dclk_prev_reg <= 1'b0;
      dbg_out_reg   <= 1'b0;
      dbg_rx_valid  <= 1'b0;
      dbg_rx_data   <= 8'h00;
    end
    else
    begin
      dclk_prev_reg <= dclk;
      dbg_rx_valid  <= 1'b0;
      case (dbg_state_reg)
        SBPA_ST_IDLE:
        begin
          if (dbg_tx_load)
          begin
            dbg_sh_reg    <= dbg_tx_data;
            dbg_cnt_reg   <= 3'h0;
            dbg_state_reg <= SBPA_ST_SHIFT;
          end
        end
        SBPA_ST_SHIFT:
        begin
          if (dclk_dn)
            dbg_out_reg <= dbg_sh_reg[7];
          if (dclk_up)
          begin
            dbg_rx_reg  <= {dbg_rx_reg[6:0], debug_serial_in};
            dbg_sh_reg  <= {dbg_sh_reg[6:0], 1'b0};
            dbg_cnt_reg <= dbg_cnt_reg + 3'h1;
            if (dbg_cnt_reg == 3'h7)
            begin
              dbg_rx_data   <= {dbg_rx_reg[6:0], debug_serial_in};
              dbg_rx_valid  <= 1'b1;
              dbg_state_reg <= SBPA_ST_IDLE;
            end
          end
        end
        default:
          dbg_state_reg <= SBPA_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers, one function per pin

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_j1_o             <= 1'b0;
      pin_j1_oe            <= 1'b0;
      pin_h2j3_o           <= 2'h0;
      pin_h2j3_oe          <= 2'h0;
      pin_misc_o           <= 6'h00;
      pin_misc_oe          <= 6'h00;
      socket_output_port_a <= 2'h0;
      pin_l1m4_o           <= 2'h0;
      pin_l1m4_oe          <= 2'h0;
      io_width16_reg       <= 1'b0;
      clock_mode           <= 2'h0;
    end
    else
    begin
      // J1: strobe, debug clock input, or attribute 1
      pin_j1_oe <= (fn_j1 == 2'h0) || ((fn_j1 == `SBPA_FN_ALT) && own_xact);
      pin_j1_o  <= (fn_j1 == 2'h0) ? ale_b : at1;
      // Trace group: watchpoints or flush counts on H2/J3/G1/G2/J4
      pin_h2j3_oe <= {2{!sense_trc}};
      pin_h2j3_o  <= (fn_trc == `SBPA_FN_DEBUG) ? trace.instr_watch[1:0]
                                                : trace.history_flush;
      pin_misc_oe[3:1] <= {3{!sense_trc}};
      pin_misc_o[3:1]  <= (fn_trc == `SBPA_FN_DEBUG)
        ? {trace.data_watch, trace.instr_watch[2]}
        : {trace.queue_flush, 1'b0};
      // J2: attribute 2 on alt select only for own transactions
      pin_misc_oe[0] <= (fn_trc == `SBPA_FN_ALT) && own_xact;
      pin_misc_o[0]  <= at2;
      // K3: attribute 0; H1: trace or attribute 3
      pin_misc_oe[4] <= (fn_k3h1 == `SBPA_FN_ALT) && own_xact;
      pin_misc_o[4]  <= at0;
      pin_misc_oe[5] <= (fn_k3h1 == `SBPA_FN_DEBUG) ||
                        ((fn_k3h1 == `SBPA_FN_ALT) && own_xact);
      pin_misc_o[5]  <= (fn_k3h1 == `SBPA_FN_DEBUG) ? trace.fetch : at3;
      socket_output_port_a <= gctrl_a_reg;
      // L1/M4: output port, strap inputs, or STS and debug out
      // Hold L1/M4 as inputs until the straps are caught
      pin_l1m4_oe <= (por_prev_reg &&
                      (fn_l1m4 == 2'h0 || fn_l1m4 == `SBPA_FN_DEBUG)) ?
                     2'h3 : 2'h0;
      pin_l1m4_o  <= (fn_l1m4 == 2'h0) ? gctrl_b_reg
                                       : {dbg_out_reg, sts};
      // J2 width input is sampled only while the trace group senses
      if (io16_samp && sense_trc)
        io_width16_reg <= pin_sync_reg[3];
      clock_mode <= strap_reg[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_OP_A_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst)
    wr_a |-> ##2 socket_output_port_a == $past(reg_wdata[1:0], 2))
    else $error("output port A did not follow write");
  AST_ATTR_EXT_RELEASED: assert property (@(posedge sys_clk) disable iff (rst)
    (xact.start && xact.initiator == SBPA_INIT_EXT) |=> !pin_misc_oe[4]
    && !pin_misc_oe[0])
    else $error("attribute driven for external master");
  AST_CHANGE_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
    (sense_edge != 8'h00) |=> ((pin_change_reg & $past(sense_edge))
    == $past(sense_edge)))
    else $error("pin change lost");
  AST_ALE_B: assert property (@(posedge sys_clk) disable iff (rst)
    (fn_j1 == 2'h0 && xact.start && xact.socket_b) |=> pin_j1_o && pin_j1_oe)
    else $error("socket B strobe missing");
  AST_STS: assert property (@(posedge sys_clk) disable iff (rst)
    (fn_l1m4 == `SBPA_FN_DEBUG && xact.start && !xact.internal)
    |=> pin_l1m4_o[0])
    else $error("transfer start missing");
  AST_AT0: assert property (@(posedge sys_clk) disable iff (rst)
    (fn_k3h1 == `SBPA_FN_ALT && xact.start &&
     xact.initiator == SBPA_INIT_CPM) |=> pin_misc_o[4] && pin_misc_oe[4])
    else $error("initiator attribute wrong");
  AST_OP_B: assert property (@(posedge sys_clk) disable iff (rst)
    (fn_l1m4 == 2'h0 && $stable(fn_l1m4)) |=> pin_l1m4_o == $past(gctrl_b_reg))
    else $error("output port B wrong");
  AST_UNSEL_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
    (sense_trc && $past(sense_trc)) |-> pin_h2j3_oe == 2'h0)
    else $error("sensed pin driven");

endmodule : sbpa_pins

// [sim/sbpa_far_model.sv]
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Card, strap resistors and idle debug host on the shared pins
module sbpa_far_model
(
  // Pins from the design, {l1m4, misc, h2j3, j1}
  input  wire logic [10:0] pin_o,
  input  wire logic [10:0] pin_oe,
  // Card sense levels and strap values
  input  wire logic [7:0]  levels,
  input  wire logic [1:0]  strap,
  // Resolved pin levels back to the design
  output logic      [10:0] pin_i
);
  logic [10:0] far_drive;

  // Straps held on L1/M4 through reset release
  // Debug clock stands still outside frames
  // Debug data in on K3 follows the sense level
  assign far_drive = {strap, levels, 1'b0};
  // Design drive wins where enabled, else the far side holds the level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & far_drive);
endmodule : sbpa_far_model

// [sim/socket_b_port_attribute_pins_tb.sv]
`timescale 1ns/10ps

module socket_b_port_attribute_pins_tb
  import sbpa_pkg::*;
;
  logic        sys_clk = 1'b0, rst = 1'b1, power_on_reset_n = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, show_cycle = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  sbpa_xact_t  xact = '0;
  sbpa_trace_t trace = '0;
  logic [7:0]  levels = 8'h00, dbg_rx_data;
  logic [1:0]  strap = 2'h2, clock_mode, socket_output_port_a;
  logic [1:0]  pin_h2j3_o, pin_h2j3_oe, pin_l1m4_o, pin_l1m4_oe;
  logic [5:0]  pin_misc_o, pin_misc_oe;
  logic        dbg_rx_valid, io_width16_reg, pin_j1_o, pin_j1_oe;
  logic [10:0] pin_i;
  int          num_errors = 0, compares = 0;

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  sbpa_pins dut
  (
    .sys_clk(sys_clk), .rst(rst), .power_on_reset_n(power_on_reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xact(xact),
    .show_cycle(show_cycle), .trace(trace), .dbg_tx_load(1'b0),
    .dbg_tx_data(8'h00), .dbg_rx_data(dbg_rx_data),
    .dbg_rx_valid(dbg_rx_valid), .io_width16_reg(io_width16_reg),
    .clock_mode(clock_mode), .pin_j1_i(pin_i[0]), .pin_j1_o(pin_j1_o),
    .pin_j1_oe(pin_j1_oe), .pin_h2j3_i(pin_i[2:1]),
    .pin_h2j3_o(pin_h2j3_o), .pin_h2j3_oe(pin_h2j3_oe),
    .pin_misc_i(pin_i[8:3]), .pin_misc_o(pin_misc_o),
    .pin_misc_oe(pin_misc_oe), .socket_output_port_a(socket_output_port_a),
    .pin_l1m4_i(pin_i[10:9]), .pin_l1m4_o(pin_l1m4_o),
    .pin_l1m4_oe(pin_l1m4_oe)
  );

  sbpa_far_model far
  (
    .pin_o({pin_l1m4_o, pin_misc_o, pin_h2j3_o, pin_j1_o}),
    .pin_oe({pin_l1m4_oe, pin_misc_oe, pin_h2j3_oe, pin_j1_oe}),
    .levels(levels), .strap(strap), .pin_i(pin_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  // One-cycle start, pins answer one edge later for one cycle
  task snd(input sbpa_xact_t x, input sbpa_trace_t t);
    @(posedge sys_clk);
    xact  <= x;
    trace <= t;
    @(posedge sys_clk);
    xact <= '0;
    #1;
  endtask : snd

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    power_on_reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk(clock_mode, 32'h2);
    rd(4'h5, 32'h6);
    chk(socket_output_port_a, 32'h0);
    rd(4'h2, 32'h0);
    rd(4'hF, 32'h0);
    wr(4'h2, 32'h3);
    @(posedge sys_clk);
    #1 chk(socket_output_port_a, 32'h3);
    wr(4'h3, 32'h1);
    @(posedge sys_clk);
    #1 chk({pin_l1m4_oe, pin_l1m4_o}, 32'hD);
    // Sense path has two sync stages, so allow settling first
    @(posedge sys_clk);
    levels <= 8'hA5;
    repeat (5) @(posedge sys_clk);
    rd(4'h0, 32'hA5);
    rd(4'h1, 32'hA5);
    wr(4'h1, 32'hFF);
    rd(4'h1, 32'h0);
    snd('{1'b1, SBPA_INIT_CPU, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0}, '0);
    chk(io_width16_reg, 32'h1);
    // Attribute and flush functions on J1, the trace group and K3/H1
    wr(4'h4, 32'h2A);
    snd('{1'b1, SBPA_INIT_CPM, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{3'h0, 2'h0, 2'h0, 2'h2, 1'b0});
    chk({pin_j1_oe, pin_j1_o}, 32'h2);
    chk(pin_misc_o[0], 32'h0);
    chk(pin_misc_o[4], 32'h1);
    chk(pin_misc_o[5], 32'h0);
    chk(pin_h2j3_o, 32'h2);
    snd('{1'b1, SBPA_INIT_CPU, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, '0);
    chk({pin_j1_oe, pin_j1_o}, 32'h3);
    chk(pin_misc_o[0], 32'h1);
    chk(pin_misc_o[4], 32'h0);
    snd('{1'b1, SBPA_INIT_CPU, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, '0);
    chk(pin_j1_o, 32'h0);
    chk(pin_misc_o[0], 32'h0);
    chk(pin_misc_o[4], 32'h0);
    chk(pin_misc_o[5], 32'h1);
    snd('{1'b1, SBPA_INIT_EXT, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, '0);
    chk({pin_j1_oe, pin_misc_oe[0], pin_misc_oe[5:4]}, 32'h0);
    // Strobe, watch and start-strobe functions
    wr(4'h4, 32'h44);
    snd('{1'b1, SBPA_INIT_CPU, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
        '{3'h3, 2'h0, 2'h0, 2'h0, 1'b0});
    chk(pin_j1_o, 32'h1);
    chk(pin_l1m4_o[0], 32'h1);
    chk(pin_h2j3_o, 32'h3);
    snd('{1'b1, SBPA_INIT_CPU, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1}, '0);
    chk(pin_l1m4_o[0], 32'h0);
    @(posedge sys_clk);
    show_cycle <= 1'b1;
    snd('{1'b1, SBPA_INIT_CPU, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1}, '0);
    chk(pin_l1m4_o[0], 32'h1);
    close_out;
  end

  // Tests need some 75 cycles; a stuck run is cut off well past that
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    close_out;
  end
endmodule : socket_b_port_attribute_pins_tb
